/* File: core/rss_alu.sv */
`timescale 1ns/100ps
`default_nettype none

module rss_alu
  import rss_pkg::*;
(
  input wire rss_op_t op_in,
  input wire logic [7:0] file_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] lit_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output logic carry_out,
  output logic nibble_carry_out,
  output logic zero_out
);

  logic [7:0] minuend;
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb
  begin
    minuend = (op_in == RSS_OP_LIT_SUB) ? lit_in : file_in;
    // Add the complement plus one: carry out is the inverted borrow
    sum = {1'b0, minuend} + {1'b0, ~acc_in} + 9'h001;
    nib = {1'b0, minuend[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;
    if (op_in == RSS_OP_ROTATE)
    begin
      result_out = {file_in[6:0], carry_in};
      carry_out = file_in[7];
      nibble_carry_out = 1'b0;
      zero_out = 1'b0;
    end
    else
    begin
      result_out = sum[7:0];
      carry_out = sum[8];
      nibble_carry_out = nib[4];
      zero_out = (sum[7:0] == 8'h00);
    end
  end

endmodule // rss_alu

`default_nettype wire

/* File: core/rss_dummy_unused.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: core/rss_exec.sv */
// Operation
// - Rotate-left-through-carry shifts file left; old bit 7 to carry, old carry to bit 0.
// - Rotate destination: 0 to accumulator, 1 back to file; only carry changes.
// - Power-down clears power-down flag and sets watchdog expiry flag.
// - Power-down zeroes watchdog counter and its prescaler in the same cycle.
// - Power-down stops oscillator and enters sleep; one word, one cycle.
// - Literal-minus-acc writes literal minus acc to acc, updates carry, nibble, zero.
// - File-minus-acc computes file minus acc, updates carry, nibble, zero in one cycle.
// - File-minus-acc destination: 0 to accumulator, 1 back to file.
// - Subtract carry is inverted borrow: set unless result underflows negative.
`timescale 1ns/100ps
`default_nettype none
`include "rss_params.svh"

module rss_exec
  import rss_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic wake_in,
  output logic osc_stop_out
);

  logic [7:0] file_mem [0:127];
  logic [7:0] acc_r;
  logic carry_r, nibble_r, zero_r;
  logic power_down_flag_r, watchdog_expiry_flag_r;
  logic [7:0] watchdog_counter_r, prescaler_r;
  logic [13:0] instr_r;
  rss_state_t state_r;
  logic wr_pend_r;
  logic [11:0] addr_r;
  logic [31:0] hrdata_r;
  logic wake_q1_r, wake_q2_r, wake_q3_r, wake_lvl_r;

  function automatic rss_op_t decode_op(input logic [13:0] w);
    if (w == `RSS_OPC_SLEEP)
      decode_op = RSS_OP_SLEEP;
    else if (w[13:8] == `RSS_OPC_ROTATE)
      decode_op = RSS_OP_ROTATE;
    else if (w[13:8] == `RSS_OPC_FILE_SUB)
      decode_op = RSS_OP_FILE_SUB;
    else if (w[13:9] == `RSS_OPC_LIT_SUB)
      decode_op = RSS_OP_LIT_SUB;
    else
      decode_op = RSS_OP_NONE;
  endfunction

  function automatic logic is_file_addr(input logic [11:0] a);
    is_file_addr = (a >= `RSS_OFS_FILE_BASE) && (a <= `RSS_OFS_FILE_LAST);
  endfunction

  // Bus write data phase
  logic wr_now, exec_go, dest_file;
  logic [6:0] file_sel;
  logic [7:0] file_val, alu_res;
  logic alu_c, alu_nibble, alu_z;
  rss_op_t exec_op;

  assign wr_now = wr_pend_r;
  assign exec_go = wr_now && (addr_r == `RSS_OFS_INSTR) && (state_r == RSS_ST_RUN);
  assign exec_op = exec_go ? decode_op(hwdata_in[13:0]) : RSS_OP_NONE;
  assign file_sel = hwdata_in[6:0];
  assign dest_file = hwdata_in[7];
  assign file_val = file_mem[file_sel];

  rss_alu i_rss_alu (
    .op_in(exec_op),
    .file_in(file_val),
    .acc_in(acc_r),
    .lit_in(hwdata_in[7:0]),
    .carry_in(carry_r),
    .result_out(alu_res),
    .carry_out(alu_c),
    .nibble_carry_out(alu_nibble),
    .zero_out(alu_z)
  );

  // AHB-Lite address phase capture; zero wait states
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
      hrdata_r <= 32'h0000_0000;
    end
    else if (hready_in)
    begin
      // Upper address bits must be zero, or writes would alias the low map
      wr_pend_r <= hsel_in && htrans_in[1] && hwrite_in && (haddr_in[31:12] == 20'h00000);
      addr_r <= haddr_in[11:0];
      if (hsel_in && htrans_in[1] && !hwrite_in)
      begin
        if (haddr_in[31:12] != 20'h00000)
          hrdata_r <= 32'h0000_0000;
        else if (haddr_in[11:0] == `RSS_OFS_INSTR)
          hrdata_r <= {18'h00000, instr_r};
        else if (haddr_in[11:0] == `RSS_OFS_ACC)
          hrdata_r <= {24'h000000, acc_r};
        else if (haddr_in[11:0] == `RSS_OFS_STATUS)
          hrdata_r <= {26'h0000000, state_r == RSS_ST_SLEEP, watchdog_expiry_flag_r,
                       power_down_flag_r, zero_r, nibble_r, carry_r};
        else if (haddr_in[11:0] == `RSS_OFS_WATCHDOG)
          hrdata_r <= {16'h0000, prescaler_r, watchdog_counter_r};
        else if (is_file_addr(haddr_in[11:0]))
          hrdata_r <= {24'h000000, file_mem[haddr_in[8:2]]};
        else
          hrdata_r <= 32'h0000_0000;
      end
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_r;

  // Last instruction word, for readback
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      instr_r <= 14'h0000;
    else if (exec_go)
      instr_r <= hwdata_in[13:0];
  end

  // Accumulator
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      acc_r <= `RSS_RST_ACC;
    else if (exec_op == RSS_OP_LIT_SUB)
      acc_r <= alu_res;
    else if ((exec_op == RSS_OP_ROTATE || exec_op == RSS_OP_FILE_SUB) && !dest_file)
      acc_r <= alu_res;
    else if (wr_now && addr_r == `RSS_OFS_ACC)
      acc_r <= hwdata_in[7:0];
  end

  // File registers; no reset, contents are undefined at power-up
  always_ff @(posedge clock_in)
  begin
    if ((exec_op == RSS_OP_ROTATE || exec_op == RSS_OP_FILE_SUB) && dest_file)
      file_mem[file_sel] <= alu_res;
    else if (wr_now && is_file_addr(addr_r))
      file_mem[addr_r[8:2]] <= hwdata_in[7:0];
  end

  // Arithmetic flags; rotate touches carry alone
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      carry_r <= 1'b0;
      nibble_r <= 1'b0;
      zero_r <= 1'b0;
    end
    else if (exec_op == RSS_OP_ROTATE)
      carry_r <= alu_c;
    else if (exec_op == RSS_OP_LIT_SUB || exec_op == RSS_OP_FILE_SUB)
    begin
      carry_r <= alu_c;
      nibble_r <= alu_nibble;
      zero_r <= alu_z;
    end
    else if (wr_now && addr_r == `RSS_OFS_STATUS)
    begin
      carry_r <= hwdata_in[`RSS_ST_CARRY];
      nibble_r <= hwdata_in[`RSS_ST_NIBBLE];
      zero_r <= hwdata_in[`RSS_ST_ZERO];
    end
  end

  // Power-down and expiry flags
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      power_down_flag_r <= `RSS_RST_POWER_DOWN;
      watchdog_expiry_flag_r <= `RSS_RST_EXPIRY;
    end
    else if (exec_op == RSS_OP_SLEEP)
    begin
      power_down_flag_r <= 1'b0;
      watchdog_expiry_flag_r <= 1'b1;
    end
  end

  // Watchdog prescaler and counter; keep running through sleep
  always_ff @(posedge clock_in)
  begin
    if (rst_in || exec_op == RSS_OP_SLEEP)
    begin
      prescaler_r <= `RSS_RST_PRESCALER;
      watchdog_counter_r <= `RSS_RST_WATCHDOG;
    end
    else
    begin
      prescaler_r <= prescaler_r + 8'h01;
      if (prescaler_r == `RSS_PRESCALE_LAST)
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
    end
  end

  // Wake pin: three stages, accept once stages two and three agree
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      wake_q1_r <= 1'b0;
      wake_q2_r <= 1'b0;
      wake_q3_r <= 1'b0;
      wake_lvl_r <= 1'b0;
    end
    else
    begin
      wake_q1_r <= wake_in;
      wake_q2_r <= wake_q1_r;
      wake_q3_r <= wake_q2_r;
      if (wake_q2_r == wake_q3_r)
        wake_lvl_r <= wake_q3_r;
    end
  end

  // Run/sleep state; a wake level held high cancels sleep next cycle
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      state_r <= RSS_ST_RUN;
    else
      case (state_r)
        RSS_ST_RUN:
          if (exec_op == RSS_OP_SLEEP)
            state_r <= RSS_ST_SLEEP;
        RSS_ST_SLEEP:
          if (wake_lvl_r)
            state_r <= RSS_ST_RUN;
        default:
          state_r <= RSS_ST_RUN;
      endcase
  end

  assign osc_stop_out = (state_r == RSS_ST_SLEEP);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_sleep_issued;
    exec_op == RSS_OP_SLEEP;
  endsequence

  sequence s_asleep_cleared;
    !power_down_flag_r && watchdog_expiry_flag_r && osc_stop_out;
  endsequence

  a_rot_carry_out: assert property (exec_op == RSS_OP_ROTATE |=> carry_r == $past(file_val[7]))
    else $error("rotate carry wrong");
  a_rot_acc_value: assert property (exec_op == RSS_OP_ROTATE && !dest_file
    |=> acc_r == {$past(file_val[6:0]), $past(carry_r)})
    else $error("rotate result wrong");
  a_rot_keeps_zero: assert property (exec_op == RSS_OP_ROTATE |=> $stable(zero_r) && $stable(nibble_r))
    else $error("rotate touched zero or nibble flag");
  a_sleep_flags_set: assert property (s_sleep_issued |=> s_asleep_cleared)
    else $error("sleep flags wrong");
  a_sleep_watchdog_clear: assert property (s_sleep_issued |=> watchdog_counter_r == 8'h00 && prescaler_r == 8'h00)
    else $error("watchdog not cleared");
  a_sleep_osc_hold: assert property (s_sleep_issued ##1 !wake_lvl_r |=> osc_stop_out)
    else $error("oscillator not held stopped");
  a_lit_sub_value: assert property (exec_op == RSS_OP_LIT_SUB
    |=> acc_r == 8'($past(hwdata_in[7:0]) - $past(acc_r)))
    else $error("literal subtract wrong");
  a_sub_borrow: assert property (exec_op == RSS_OP_FILE_SUB
    |=> carry_r == ($past(file_val) >= $past(acc_r)) && zero_r == ($past(file_val) == $past(acc_r)))
    else $error("file subtract flags wrong");
  a_sub_dest_file: assert property (exec_op == RSS_OP_FILE_SUB && dest_file |=> $stable(acc_r))
    else $error("file subtract wrote accumulator");
  a_rot_dest_file: assert property (exec_op == RSS_OP_ROTATE && dest_file |=> $stable(acc_r))
    else $error("rotate to file wrote accumulator");
  a_sub_nibble: assert property (exec_op == RSS_OP_FILE_SUB
    |=> nibble_r == ($past(file_val[3:0]) >= $past(acc_r[3:0])))
    else $error("file subtract nibble flag wrong");
  a_lit_borrow: assert property (exec_op == RSS_OP_LIT_SUB
    |=> carry_r == ($past(hwdata_in[7:0]) >= $past(acc_r)))
    else $error("literal subtract carry wrong");

endmodule // rss_exec

`default_nettype wire

/* File: core/rss_params.svh */
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// Register byte offsets
`define RSS_OFS_INSTR 12'h000
`define RSS_OFS_ACC 12'h004
`define RSS_OFS_STATUS 12'h008
`define RSS_OFS_WATCHDOG 12'h00C
`define RSS_OFS_FILE_BASE 12'h200
`define RSS_OFS_FILE_LAST 12'h3FC

// Status register bit positions
`define RSS_ST_CARRY 0
`define RSS_ST_NIBBLE 1
`define RSS_ST_ZERO 2
`define RSS_ST_POWER_DOWN 3
`define RSS_ST_EXPIRY 4
`define RSS_ST_SLEEPING 5

// Reset values
`define RSS_RST_ACC 8'h00
`define RSS_RST_POWER_DOWN 1'b1
`define RSS_RST_EXPIRY 1'b1
`define RSS_RST_WATCHDOG 8'h00
`define RSS_RST_PRESCALER 8'h00

// Opcode fields
`define RSS_OPC_ROTATE 6'h0D
`define RSS_OPC_FILE_SUB 6'h02
`define RSS_OPC_LIT_SUB 5'h1E
`define RSS_OPC_SLEEP 14'h0063

// Watchdog prescaler wrap count
`define RSS_PRESCALE_LAST 8'hFF

`endif

/* File: core/rss_pkg.sv */
`default_nettype none

package rss_pkg;

  typedef enum logic [2:0] {
    RSS_OP_NONE = 3'h0,
    RSS_OP_ROTATE = 3'h1,
    RSS_OP_FILE_SUB = 3'h2,
    RSS_OP_LIT_SUB = 3'h3,
    RSS_OP_SLEEP = 3'h4
  } rss_op_t;

  typedef enum logic {
    RSS_ST_RUN = 1'b0,
    RSS_ST_SLEEP = 1'b1
  } rss_state_t;

endpackage

`default_nettype wire

/* File: testbench/rotate_subtract_sleep_exec_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rss_params.svh"

module rotate_subtract_sleep_exec_bench;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic wake = 1'h0;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic osc_stop;
  int errors = 0;
  int checks = 0;

  rss_exec i_rss_exec (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .hsel_in(hsel),
    .haddr_in(haddr),
    .htrans_in(htrans),
    .hwrite_in(hwrite),
    .hsize_in(3'h2),
    .hwdata_in(hwdata),
    .hready_in(hready),
    .hreadyout_out(hready),
    .hresp_out(hresp),
    .hrdata_out(hrdata),
    .wake_in(wake),
    .osc_stop_out(osc_stop)
  );

  initial
  begin
    forever #5 clock_in = ~clock_in;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_ready;
    @(posedge clock_in);
    while (hready !== 1'h1)
      @(posedge clock_in);
  endtask

  // Address phase held until hready, then IDLE with data held until hready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask

  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'h0, a, 32'h0, q);
    check(name, q, exp);
  endtask

  task automatic t_regs;
    rd("status_reset", `RSS_OFS_STATUS, 32'h18);
    rd("acc_reset", `RSS_OFS_ACC, 32'h0);
    wr(12'h100, 32'hFF);
    rd("unmapped", 12'h100, 32'h0);
    // Flag bits 3..5 must ignore the write
    wr(`RSS_OFS_STATUS, 32'hFF);
    rd("status_ro", `RSS_OFS_STATUS, 32'h1F);
  endtask

  // Top file address, Z preset to show rotate leaves it alone
  task automatic t_rotate;
    wr(`RSS_OFS_FILE_LAST, 32'hE6);
    wr(`RSS_OFS_STATUS, 32'h04);
    wr(`RSS_OFS_INSTR, 32'h0D7F);
    rd("rot_acc", `RSS_OFS_ACC, 32'hCC);
    rd("rot_status", `RSS_OFS_STATUS, 32'h1D);
    rd("rot_file_kept", `RSS_OFS_FILE_LAST, 32'hE6);
    wr(`RSS_OFS_INSTR, 32'h0DFF);
    rd("rot_file", `RSS_OFS_FILE_LAST, 32'hCD);
    rd("rot_acc_kept", `RSS_OFS_ACC, 32'hCC);
    rd("rot_status2", `RSS_OFS_STATUS, 32'h1D);
  endtask

  task automatic t_lit_sub;
    wr(`RSS_OFS_STATUS, 32'h00);
    wr(`RSS_OFS_ACC, 32'h02);
    wr(`RSS_OFS_INSTR, 32'h3C01);
    rd("lit_neg", `RSS_OFS_ACC, 32'hFF);
    rd("lit_neg_st", `RSS_OFS_STATUS, 32'h18);
    wr(`RSS_OFS_ACC, 32'h02);
    wr(`RSS_OFS_INSTR, 32'h3D02);
    rd("lit_zero", `RSS_OFS_ACC, 32'h00);
    rd("lit_zero_st", `RSS_OFS_STATUS, 32'h1F);
  endtask

  task automatic t_file_sub;
    wr(`RSS_OFS_FILE_BASE, 32'h03);
    wr(`RSS_OFS_ACC, 32'h02);
    wr(`RSS_OFS_INSTR, 32'h0280);
    rd("fs_file", `RSS_OFS_FILE_BASE, 32'h01);
    rd("fs_acc_kept", `RSS_OFS_ACC, 32'h02);
    rd("fs_pos_st", `RSS_OFS_STATUS, 32'h1B);
    wr(`RSS_OFS_INSTR, 32'h0200);
    rd("fs_acc", `RSS_OFS_ACC, 32'hFF);
    rd("fs_file_kept", `RSS_OFS_FILE_BASE, 32'h01);
    rd("fs_neg_st", `RSS_OFS_STATUS, 32'h18);
    rd("fs_instr", `RSS_OFS_INSTR, 32'h0200);
  endtask

  task automatic t_sleep;
    logic [31:0] q;
    // Long enough for the counter to leave zero
    repeat (600) @(posedge clock_in);
    xfer(1'h0, `RSS_OFS_WATCHDOG, 32'h0, q);
    check("wd_running", {31'h0, q[7:0] != 8'h0}, 32'h1);
    wr(`RSS_OFS_INSTR, 32'h0063);
    xfer(1'h0, `RSS_OFS_WATCHDOG, 32'h0, q);
    check("wd_cleared", q, 32'h0);
    check("osc_stop", {31'h0, osc_stop}, 32'h1);
    rd("sleep_st", `RSS_OFS_STATUS, 32'h30);
    wr(`RSS_OFS_INSTR, 32'h0D00);
    rd("sleep_instr", `RSS_OFS_INSTR, 32'h0063);
    wake <= 1'h1;
    repeat (6) @(posedge clock_in);
    wake <= 1'h0;
    for (int n = 0; n < 20 && osc_stop !== 1'h0; n++)
      @(posedge clock_in);
    check("woken", {31'h0, osc_stop}, 32'h0);
    rd("woken_st", `RSS_OFS_STATUS, 32'h10);
  endtask

  initial
  begin
    repeat (5000) @(posedge clock_in);
    errors++;
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'h0;
    @(posedge clock_in);
    t_regs();
    t_rotate();
    t_lit_sub();
    t_file_sub();
    t_sleep();
    check("hresp", {31'h0, hresp}, 32'h0);
    summarize();
  end
endmodule // rotate_subtract_sleep_exec_bench

`default_nettype wire
